// ---- include/sqtc_map.vh ----
`ifndef SQTC_MAP_VH
`define SQTC_MAP_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define SQTC_IDX_GEN_CFG        6'h00
`define SQTC_IDX_LINE_DELAY     6'h01
`define SQTC_IDX_INTEG_SETUP    6'h02
`define SQTC_IDX_ACTIVE_REGION  6'h03
`define SQTC_IDX_SPARE_WORD     6'h04
`define SQTC_IDX_DARK_ROW       6'h05
`define SQTC_IDX_PADDING_ROW    6'h06
`define SQTC_IDX_TIMING_UNIT    6'h07
`define SQTC_IDX_FRAME_RESET    6'h08
`define SQTC_IDX_STATUS         6'h10

// ****************************************
// reset values
// ****************************************
`define SQTC_RST_GEN_CFG        16'h0000
`define SQTC_RST_LINE_DELAY     16'h0000
`define SQTC_RST_INTEG_SETUP    16'h0004
`define SQTC_RST_ACTIVE_REGION  16'h0001
`define SQTC_RST_DARK_ROW       16'h0102
`define SQTC_RST_PADDING_ROW    16'h0000
`define SQTC_RST_TIMING_UNIT    16'h0001
`define SQTC_RST_FRAME_RESET    16'h0000

// ****************************************
// writable bits per register
// ****************************************
`define SQTC_MASK_GEN_CFG       16'h3C42
`define SQTC_MASK_LINE_DELAY    16'hFFFF
`define SQTC_MASK_INTEG_SETUP   16'h0007
`define SQTC_MASK_ACTIVE_REGION 16'h00FF
`define SQTC_MASK_DARK_ROW      16'h01FF
`define SQTC_MASK_PADDING_ROW   16'h0FFF
`define SQTC_MASK_TIMING_UNIT   16'hFFFF
`define SQTC_MASK_FRAME_RESET   16'hFFFF

// ****************************************
// field positions
// ****************************************
`define SQTC_GEN_ROLLING        1
`define SQTC_GEN_DELAY_EN       6
`define SQTC_GEN_STATS_WIN      10
`define SQTC_GEN_MON_LO         11
`define SQTC_INTEG_DUAL         0
`define SQTC_INTEG_TRIPLE       1
`define SQTC_INTEG_LEN_MODE     2
`define SQTC_DARK_GATE_FIRST    8

// ****************************************
// bus responses
// ****************************************
`define SQTC_RESP_OKAY          2'h0
`define SQTC_RESP_SLVERR        2'h2

`endif

// ---- rtl/sqtc_unit_tick.v ----
`timescale 1ns/10ps
// ****************************************
// timing unit divider
// ****************************************
module sqtc_unit_tick #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             enable,
	input  wire [WIDTH-1:0] unit,
	output reg              tick
);

	reg  [WIDTH-1:0] count_reg;
	wire [WIDTH-1:0] last;

	// a zero unit behaves as one clock period
	assign last = (unit == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} : unit - {{(WIDTH-1){1'b0}}, 1'b1};

	always @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= {WIDTH{1'b0}};
			tick      <= 1'b0;
		end else if (!enable) begin
			count_reg <= {WIDTH{1'b0}};
			tick      <= 1'b0;
		end else if (count_reg >= last) begin
			count_reg <= {WIDTH{1'b0}};
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			tick      <= 1'b0;
		end
	end

endmodule // sqtc_unit_tick

// ---- rtl/sqtc_seq_config.v ----
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - statistics window bit: all windows or one
// - three-bit field selects monitor pin signals
// - rolling: line extension count pads lines
// - post-transfer delay before readout, when enabled
// - dual-slope integration only in global shutter
// - triple-slope integration only in global shutter
// - length interpretation bit, reset one
// - dark row count 1 to 255
// - first-line gating bit blanks first line
// - padding rows 0 to 4095, rolling only
// - global: timing unit in clocks, resets one
// - span is reset or frame length, scaled
// - delay applied only while enable set
`include "sqtc_map.vh"

module sqtc_seq_config #(
	parameter ADDR_WIDTH = 8
) (
	input  wire                  clk,
	input  wire                  rst_n,
	// ****************************************
	// axi4-lite slave
	// ****************************************
	input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire [2:0]            s_axi_awprot,
	input  wire                  s_axi_awvalid,
	output reg                   s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output reg                   s_axi_wready,
	output reg  [1:0]            s_axi_bresp,
	output reg                   s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire [2:0]            s_axi_arprot,
	input  wire                  s_axi_arvalid,
	output reg                   s_axi_arready,
	output reg  [31:0]           s_axi_rdata,
	output reg  [1:0]            s_axi_rresp,
	output reg                   s_axi_rvalid,
	input  wire                  s_axi_rready,
	// ****************************************
	// sequencer side
	// ****************************************
	output reg                   rolling_mode,
	output reg                   stats_window_only,
	output reg  [1:0]            monitor_out,
	output reg  [7:0]            line_extension_count,
	output reg  [7:0]            post_transfer_delay,
	output reg                   dual_slope_en,
	output reg                   triple_slope_en,
	output reg                   length_interpretation,
	output reg  [7:0]            active_region_select,
	output reg  [7:0]            dark_row_count,
	output reg                   first_line_gate,
	output reg  [11:0]           padding_row_count,
	output reg  [15:0]           timing_unit,
	output reg                   unit_tick,
	output reg  [31:0]           reset_span_cycles,
	output reg  [31:0]           frame_span_cycles
);

	// ****************************************
	// configuration storage
	// ****************************************
	reg  [15:0]           gen_cfg_reg;
	reg  [15:0]           line_delay_reg;
	reg  [15:0]           integ_setup_reg;
	reg  [15:0]           active_region_reg;
	reg  [15:0]           dark_row_reg;
	reg  [15:0]           padding_row_reg;
	reg  [15:0]           timing_unit_reg;
	reg  [15:0]           frame_reset_reg;
	reg                   dark_zero_reg;
	reg  [7:0]            tick_count_reg;

	// ****************************************
	// bus state
	// ****************************************
	reg                   aw_hold_reg;
	reg                   w_hold_reg;
	reg  [ADDR_WIDTH-1:0] aw_addr_reg;
	reg  [31:0]           w_data_reg;
	reg  [3:0]            w_strb_reg;
	reg  [31:0]           rd_data_next;
	reg                   rd_hit_next;
	reg                   wr_hit_next;

	wire [5:0]            wr_idx;
	wire [5:0]            rd_idx;
	wire [15:0]           lane_mask;
	wire                  do_write;
	wire                  tick_raw;
	wire                  global_mode;
	wire [15:0]           span_write;
	wire [31:0]           span_product;

	assign wr_idx      = aw_addr_reg[7:2];
	assign rd_idx      = s_axi_araddr[7:2];
	assign lane_mask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign do_write    = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign global_mode = !gen_cfg_reg[`SQTC_GEN_ROLLING];
	assign span_write  = w_data_reg[15:0];
	// operands widened so the full product is kept
	assign span_product = {16'h0000, frame_reset_reg} * {16'h0000, timing_unit_reg};

	// merge strobed lanes into the writable bits only
	function [15:0] merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [15:0] lanes;
		input [15:0] field_mask;
		reg   [15:0] m;
		begin
			m     = lanes & field_mask;
			merge = (old_val & ~m) | (new_val & m);
		end
	endfunction

	// ****************************************
	// write address and data channels
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SQTC_RESP_OKAY;
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			aw_addr_reg   <= {ADDR_WIDTH{1'b0}};
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
		end else begin
			s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit_next ? `SQTC_RESP_OKAY : `SQTC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_reg   <= 1'b0;
				w_hold_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ****************************************
	// write decode
	// ****************************************
	always @* begin
		case (wr_idx)
			`SQTC_IDX_GEN_CFG,
			`SQTC_IDX_LINE_DELAY,
			`SQTC_IDX_INTEG_SETUP,
			`SQTC_IDX_ACTIVE_REGION,
			`SQTC_IDX_SPARE_WORD,
			`SQTC_IDX_DARK_ROW,
			`SQTC_IDX_PADDING_ROW,
			`SQTC_IDX_TIMING_UNIT,
			`SQTC_IDX_FRAME_RESET,
			`SQTC_IDX_STATUS: wr_hit_next = 1'b1;
			default: wr_hit_next = 1'b0;
		endcase
	end

	// ****************************************
	// register file
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			gen_cfg_reg       <= `SQTC_RST_GEN_CFG;
			line_delay_reg    <= `SQTC_RST_LINE_DELAY;
			integ_setup_reg   <= `SQTC_RST_INTEG_SETUP;
			active_region_reg <= `SQTC_RST_ACTIVE_REGION;
			dark_row_reg      <= `SQTC_RST_DARK_ROW;
			padding_row_reg   <= `SQTC_RST_PADDING_ROW;
			timing_unit_reg   <= `SQTC_RST_TIMING_UNIT;
			frame_reset_reg   <= `SQTC_RST_FRAME_RESET;
		end else if (do_write) begin
			// reserved bits and the spare word never store: tolerated
			case (wr_idx)
				`SQTC_IDX_GEN_CFG: gen_cfg_reg <=
					merge(gen_cfg_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_GEN_CFG);
				`SQTC_IDX_LINE_DELAY: line_delay_reg <=
					merge(line_delay_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_LINE_DELAY);
				`SQTC_IDX_INTEG_SETUP: integ_setup_reg <=
					merge(integ_setup_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_INTEG_SETUP);
				`SQTC_IDX_ACTIVE_REGION: active_region_reg <=
					merge(active_region_reg, w_data_reg[15:0], lane_mask,
						`SQTC_MASK_ACTIVE_REGION);
				`SQTC_IDX_DARK_ROW: dark_row_reg <=
					merge(dark_row_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_DARK_ROW);
				`SQTC_IDX_PADDING_ROW: padding_row_reg <=
					merge(padding_row_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_PADDING_ROW);
				`SQTC_IDX_TIMING_UNIT: timing_unit_reg <=
					merge(timing_unit_reg, w_data_reg[15:0], lane_mask, `SQTC_MASK_TIMING_UNIT);
				`SQTC_IDX_FRAME_RESET: frame_reset_reg <=
					merge(frame_reset_reg, span_write, lane_mask, `SQTC_MASK_FRAME_RESET);
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	always @* begin
		rd_data_next = 32'h00000000;
		rd_hit_next  = 1'b1;
		case (rd_idx)
			`SQTC_IDX_GEN_CFG:       rd_data_next[15:0] = gen_cfg_reg;
			`SQTC_IDX_LINE_DELAY:    rd_data_next[15:0] = line_delay_reg;
			`SQTC_IDX_INTEG_SETUP:   rd_data_next[15:0] = integ_setup_reg;
			`SQTC_IDX_ACTIVE_REGION: rd_data_next[15:0] = active_region_reg;
			`SQTC_IDX_SPARE_WORD:    rd_data_next[15:0] = 16'h0000;
			`SQTC_IDX_DARK_ROW:      rd_data_next[15:0] = dark_row_reg;
			`SQTC_IDX_PADDING_ROW:   rd_data_next[15:0] = padding_row_reg;
			`SQTC_IDX_TIMING_UNIT:   rd_data_next[15:0] = timing_unit_reg;
			`SQTC_IDX_FRAME_RESET:   rd_data_next[15:0] = frame_reset_reg;
			`SQTC_IDX_STATUS: begin
				rd_data_next[0]    = rolling_mode;
				rd_data_next[1]    = dark_zero_reg;
				rd_data_next[2]    = dual_slope_en;
				rd_data_next[3]    = triple_slope_en;
				rd_data_next[15:8] = tick_count_reg;
			end
			default: rd_hit_next = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SQTC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data_next;
			s_axi_rresp   <= rd_hit_next ? `SQTC_RESP_OKAY : `SQTC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// timing unit divider
	// ****************************************
	sqtc_unit_tick #(
		.WIDTH (16)
	) u_unit_tick (
		.clk    (clk),
		.rst_n  (rst_n),
		.enable (global_mode),
		.unit   (timing_unit_reg),
		.tick   (tick_raw)
	);

	// ****************************************
	// sequencer controls
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			rolling_mode          <= 1'b0;
			stats_window_only     <= 1'b0;
			line_extension_count  <= 8'h00;
			post_transfer_delay   <= 8'h00;
			dual_slope_en         <= 1'b0;
			triple_slope_en       <= 1'b0;
			length_interpretation <= 1'b1;
			active_region_select  <= 8'h01;
			dark_row_count        <= 8'h02;
			first_line_gate       <= 1'b1;
			padding_row_count     <= 12'h000;
			timing_unit           <= `SQTC_RST_TIMING_UNIT;
			unit_tick             <= 1'b0;
			dark_zero_reg         <= 1'b0;
			tick_count_reg        <= 8'h00;
		end else begin
			rolling_mode          <= gen_cfg_reg[`SQTC_GEN_ROLLING];
			stats_window_only     <= gen_cfg_reg[`SQTC_GEN_STATS_WIN];
			line_extension_count  <= global_mode ? 8'h00 : line_delay_reg[7:0];
			post_transfer_delay   <= gen_cfg_reg[`SQTC_GEN_DELAY_EN] ?
				line_delay_reg[15:8] : 8'h00;
			dual_slope_en         <= global_mode &&
				integ_setup_reg[`SQTC_INTEG_DUAL];
			triple_slope_en       <= global_mode &&
				integ_setup_reg[`SQTC_INTEG_TRIPLE];
			length_interpretation <= integ_setup_reg[`SQTC_INTEG_LEN_MODE];
			active_region_select  <= active_region_reg[7:0];
			// zero is illegal; hold at the minimum of one
			dark_row_count        <= (dark_row_reg[7:0] == 8'h00) ?
				8'h01 : dark_row_reg[7:0];
			dark_zero_reg         <= (dark_row_reg[7:0] == 8'h00);
			first_line_gate       <= dark_row_reg[`SQTC_DARK_GATE_FIRST];
			padding_row_count     <= global_mode ? 12'h000 : padding_row_reg[11:0];
			timing_unit           <= timing_unit_reg;
			unit_tick             <= tick_raw;
			if (tick_raw) begin
				tick_count_reg <= tick_count_reg + 8'h01;
			end
		end
	end

	// ****************************************
	// frame or reset span in clock cycles
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			reset_span_cycles <= 32'h00000000;
			frame_span_cycles <= 32'h00000000;
		end else if (!global_mode) begin
			reset_span_cycles <= 32'h00000000;
			frame_span_cycles <= 32'h00000000;
		end else if (integ_setup_reg[`SQTC_INTEG_LEN_MODE]) begin
			reset_span_cycles <= 32'h00000000;
			frame_span_cycles <= span_product;
		end else begin
			reset_span_cycles <= span_product;
			frame_span_cycles <= 32'h00000000;
		end
	end

	// ****************************************
	// monitor pins
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			monitor_out <= 2'h0;
		end else begin
			case (gen_cfg_reg[`SQTC_GEN_MON_LO+2:`SQTC_GEN_MON_LO])
				3'h0: monitor_out <= 2'h0;
				3'h1: monitor_out <= {tick_raw, rolling_mode};
				3'h2: monitor_out <= {dual_slope_en, triple_slope_en};
				3'h3: monitor_out <= {first_line_gate, stats_window_only};
				3'h4: monitor_out <= {gen_cfg_reg[`SQTC_GEN_DELAY_EN], length_interpretation};
				3'h5: monitor_out <= {s_axi_bvalid, s_axi_rvalid};
				3'h6: monitor_out <= {aw_hold_reg, w_hold_reg};
				3'h7: monitor_out <= {dark_zero_reg, tick_count_reg[0]};
				default: monitor_out <= 2'h0;
			endcase
		end
	end

endmodule // sqtc_seq_config

// ---- verif/sqtc_seq_config_props.sv ----
`timescale 1ns/10ps
module sqtc_seq_config_props (
	input wire        clk,
	input wire        rst_n,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        rolling_mode,
	input wire [7:0]  line_extension_count,
	input wire        dual_slope_en,
	input wire        triple_slope_en,
	input wire        length_interpretation,
	input wire [7:0]  dark_row_count,
	input wire        first_line_gate,
	input wire [11:0] padding_row_count,
	input wire [15:0] timing_unit,
	input wire        unit_tick,
	input wire [31:0] reset_span_cycles,
	input wire [31:0] frame_span_cycles
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	reset_values_a: assert property ($rose(rst_n) |-> length_interpretation &&
		first_line_gate && timing_unit == 16'h0001 && dark_row_count == 8'h02)
		else $error("config outputs not at reset values");
	dual_global_a: assert property (dual_slope_en |-> !rolling_mode)
		else $error("dual slope active in rolling mode");
	triple_global_a: assert property (triple_slope_en |-> !rolling_mode)
		else $error("triple slope active in rolling mode");
	line_ext_a: assert property (!rolling_mode |-> line_extension_count == 8'h00)
		else $error("line extension outside rolling mode");
	padding_rows_a: assert property (!rolling_mode |-> padding_row_count == 12'h000)
		else $error("padding rows outside rolling mode");
	dark_min_a: assert property (dark_row_count != 8'h00)
		else $error("dark row count zero");
	span_select_a: assert property ((length_interpretation ? reset_span_cycles :
		frame_span_cycles) == 32'h0)
		else $error("wrong span output active");
	span_rolling_a: assert property (rolling_mode |-> reset_span_cycles == 32'h0 &&
		frame_span_cycles == 32'h0)
		else $error("span driven in rolling mode");
	tick_global_a: assert property (rolling_mode && $past(rolling_mode) &&
		$past(rolling_mode, 2) |-> !unit_tick)
		else $error("unit tick in rolling mode");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (unit_tick && !rolling_mode);
endmodule // sqtc_seq_config_props

bind sqtc_seq_config sqtc_seq_config_props u_props (.clk, .rst_n, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .rolling_mode, .line_extension_count, .dual_slope_en,
	.triple_slope_en, .length_interpretation, .dark_row_count, .first_line_gate,
	.padding_row_count, .timing_unit, .unit_tick, .reset_span_cycles, .frame_span_cycles);

// ---- verif/sequencer_timing_config_bench.sv ----
`timescale 1ns/10ps
`include "sqtc_map.vh"
module sequencer_timing_config_bench;
	reg         clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	reg  [7:0]  awaddr, araddr;
	reg  [31:0] wdata, d;
	reg  [3:0]  wstrb;
	reg  [1:0]  r;
	wire        awready, wready, bvalid, arready, rvalid, rolling_mode, stats_window_only;
	wire        dual_slope_en, triple_slope_en, length_interpretation, first_line_gate, unit_tick;
	wire [1:0]  bresp, rresp, monitor_out;
	wire [31:0] rdata, reset_span_cycles, frame_span_cycles;
	wire [7:0]  line_extension_count, post_transfer_delay, active_region_select, dark_row_count;
	wire [11:0] padding_row_count;
	wire [15:0] timing_unit;
	integer     err_total, checked, i, n;
	reg [143:0] rst_all, mask_all;

	sqtc_seq_config dut (.clk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rolling_mode, .stats_window_only,
		.monitor_out, .line_extension_count, .post_transfer_delay, .dual_slope_en,
		.triple_slope_en, .length_interpretation, .active_region_select, .dark_row_count,
		.first_line_gate, .padding_row_count, .timing_unit, .unit_tick, .reset_span_cycles,
		.frame_span_cycles);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task give_verdict;
		begin
			$display("checked=%0d err_total=%0d", checked, err_total);
			if (err_total == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	task wr(input [5:0] idx, input [15:0] v, input [3:0] st, output [1:0] resp);
		reg done;
		reg aw_t;
		reg w_t;
		reg b_t;
		reg [1:0] b_resp;
		integer k;
		begin
			@(posedge clk);
			awaddr  <= {idx, 2'b00};
			wdata   <= {16'h0000, v};
			wstrb   <= st;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
			done = 1'b0;
			for (k = 0; k < 50 && !done; k = k + 1) begin
				// capture what the slave shows for the coming edge
				#1;
				aw_t = awready;
				w_t = wready;
				b_t = bvalid;
				b_resp = bresp;
				@(posedge clk);
				if (awvalid && aw_t)
					awvalid <= 1'b0;
				if (wvalid && w_t)
					wvalid <= 1'b0;
				if (b_t === 1'b1) begin
					resp = b_resp;
					bready <= 1'b0;
					done = 1'b1;
				end
			end
			if (!done)
				err_total = err_total + 1;
		end
	endtask

	task get(input [5:0] idx, output [31:0] v, output [1:0] resp);
		reg done;
		reg ar_t;
		reg r_t;
		reg [31:0] r_data;
		reg [1:0] r_resp;
		integer k;
		begin
			@(posedge clk);
			araddr  <= {idx, 2'b00};
			arvalid <= 1'b1;
			rready  <= 1'b1;
			done = 1'b0;
			for (k = 0; k < 50 && !done; k = k + 1) begin
				#1;
				ar_t = arready;
				r_t = rvalid;
				r_data = rdata;
				r_resp = rresp;
				@(posedge clk);
				if (arvalid && ar_t)
					arvalid <= 1'b0;
				if (r_t === 1'b1) begin
					v = r_data;
					resp = r_resp;
					rready <= 1'b0;
					done = 1'b1;
				end
			end
			if (!done)
				err_total = err_total + 1;
		end
	endtask

	// full-lane write, then let outputs catch up
	task put(input [5:0] idx, input [15:0] v);
		begin
			wr(idx, v, 4'h3, r);
			repeat (2) @(posedge clk);
			#1;
		end
	endtask

	initial begin
		#100000;
		err_total = err_total + 1;
		give_verdict;
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		err_total = 0;
		checked = 0;
		rst_all = {`SQTC_RST_FRAME_RESET, `SQTC_RST_TIMING_UNIT, `SQTC_RST_PADDING_ROW,
			`SQTC_RST_DARK_ROW, 16'h0000, `SQTC_RST_ACTIVE_REGION, `SQTC_RST_INTEG_SETUP,
			`SQTC_RST_LINE_DELAY, `SQTC_RST_GEN_CFG};
		mask_all = {`SQTC_MASK_FRAME_RESET, `SQTC_MASK_TIMING_UNIT, `SQTC_MASK_PADDING_ROW,
			`SQTC_MASK_DARK_ROW, 16'h0000, `SQTC_MASK_ACTIVE_REGION, `SQTC_MASK_INTEG_SETUP,
			`SQTC_MASK_LINE_DELAY, `SQTC_MASK_GEN_CFG};
		rst_n = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(active_region_select, 8'h01);
		for (i = 1; i < 9; i = i + 1) begin
			get(i, d, r);
			chk(d, rst_all[i*16 +: 16]);
		end
		$display("test reset values done");
		// ****************************************
		// all ones: masks, rolling gating
		// ****************************************
		for (i = 0; i < 9; i = i + 1) begin
			put(i, 16'hFFFF);
			get(i, d, r);
			chk(d, mask_all[i*16 +: 16]);
		end
		chk({line_extension_count, post_transfer_delay}, 16'hFFFF);
		chk({padding_row_count, stats_window_only}, 13'h1FFF);
		chk({dual_slope_en, triple_slope_en}, 2'b00);
		chk(frame_span_cycles | reset_span_cycles, 32'h0);
		chk(active_region_select, 8'hFF);
		put(0, 16'h0000);
		chk({line_extension_count, post_transfer_delay}, 16'h0000);
		chk({padding_row_count, stats_window_only}, 13'h0000);
		chk({dual_slope_en, triple_slope_en, monitor_out}, 4'hC);
		chk(frame_span_cycles, 32'hFFFE0001);
		for (i = 2; i < 7; i = i + 1) begin
			put(0, (i << 11) | 16'h0040);
			chk(monitor_out, (i == 3) ? 2'b10 : ((i > 4) ? 2'b00 : 2'b11));
		end
		chk(post_transfer_delay, 8'hFF);
		$display("test field gating done");
		// ****************************************
		// lanes, dark rows, spans, tick
		// ****************************************
		put(1, 16'h0000);
		wr(1, 16'hABCD, 4'h1, r);
		wr(1, 16'h1234, 4'h2, r);
		get(1, d, r);
		chk(d, 32'h000012CD);
		put(5, 16'h0000);
		chk({dark_row_count, first_line_gate}, 9'h002);
		get(5, d, r);
		chk(d, 32'h0);
		get(`SQTC_IDX_STATUS, d, r);
		chk(d[3:0], 4'hE);
		put(5, 16'h00FF);
		chk(dark_row_count, 8'hFF);
		put(0, 16'h0000);
		put(7, 16'h0003);
		chk(timing_unit, 16'h0003);
		put(8, 16'h1234);
		put(2, 16'h0004);
		chk(frame_span_cycles, 32'h369C);
		chk(reset_span_cycles, 32'h0);
		put(2, 16'h0000);
		chk(frame_span_cycles, 32'h0);
		chk(reset_span_cycles, 32'h369C);
		chk(length_interpretation, 1'b0);
		n = 0;
		for (i = 0; i < 30; i = i + 1) begin
			@(posedge clk);
			#1;
			if (unit_tick === 1'b1)
				n = n + 1;
		end
		chk(n, 10);
		put(0, 16'h0002);
		chk(rolling_mode, 1'b1);
		n = 0;
		for (i = 0; i < 12; i = i + 1) begin
			@(posedge clk);
			#1;
			if (unit_tick !== 1'b0)
				n = n + 1;
		end
		chk(n, 0);
		$display("test spans and tick done");
		wr(6'h20, 16'h1111, 4'h3, r);
		chk(r, `SQTC_RESP_SLVERR);
		get(6'h20, d, r);
		chk(r, `SQTC_RESP_SLVERR);
		chk(d, 32'h0);
		$display("test unmapped done");
		give_verdict;
	end
endmodule // sequencer_timing_config_bench
